// File: icyc_defs.svh
/*
 * Offsets, field positions and timing counts shared by both ends of the isochronous cycle link.
 * Assumes a 100 MHz clock; every count below is in cycles of that clock.
 */
`ifndef ICYC_DEFS_SVH
`define ICYC_DEFS_SVH

`define CLK_NS 10
`define CEIL_CLKS(ns) (12'(((ns) + `CLK_NS - 1) / `CLK_NS))
`define FLOOR_CLKS(ns) (12'((ns) / `CLK_NS))

// Bus cycle and exchange window
`define BUS_CYCLE_NS 40000
`define BUS_CYCLE_CLKS `FLOOR_CLKS(`BUS_CYCLE_NS)
`define XFER_BASE_NS 1000
`define XFER_AXIS_NS 2000
`define WINDOW_SINGLE_CLKS (`CEIL_CLKS(`XFER_BASE_NS + `XFER_AXIS_NS))
`define WINDOW_DUAL_CLKS (`CEIL_CLKS(`XFER_BASE_NS + 2 * `XFER_AXIS_NS))
`define MASTER_OFFSET_NS 500
`define MASTER_OFFSET_CLKS `CEIL_CLKS(`MASTER_OFFSET_NS)

// Drive instants relative to cycle start
`define INPUT_INSTANT_NS 36000
`define INPUT_INSTANT_CLKS `CEIL_CLKS(`INPUT_INSTANT_NS)
`define OUTPUT_INSTANT_NS 8000
`define OUTPUT_INSTANT_CLKS `CEIL_CLKS(`OUTPUT_INSTANT_NS)

// Master phases after the exchange
`define TOKEN_HOLD_NS 15000
`define TOKEN_HOLD_CLKS `FLOOR_CLKS(`TOKEN_HOLD_NS)
`define GAP_NS 2000
`define GAP_CLKS `CEIL_CLKS(`GAP_NS)
`define RES_SPACING_NS 1000
`define RES_SPACING_CLKS `CEIL_CLKS(`RES_SPACING_NS)

// Frame layout: header, 4 words per axis, trailer
`define LAST_IDX_SINGLE 4'h5
`define LAST_IDX_DUAL 4'h9
`define AXIS_B_FIRST 4'h5

// Word contents
`define GC_WORD 16'h0001
`define TOKEN_SELF 16'h0000
`define TOKEN_OTHER 16'h0001
`define POP_MSB 15
`define POP_LSB 14
`define RESP_DONE_BIT 13
`define PNUM_MSB 3

`endif

// File: icyc_pkg.sv
/*
 * Types shared by the isochronous cycle master, the drive end and their link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package icyc_pkg;
	// Kind of each word on the link
	typedef enum logic [2:0] {K_GC, K_HDR, K_PARAM, K_PROC, K_TRL, K_ACYC, K_TOKEN} word_kind_e;
	// Parameter channel request in bits 15:14 of the identifier word
	typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_FAULT} param_op_e;
endpackage : icyc_pkg

// File: icyc_link.sv
/*
 * Word link between the cycle master and a drive: one stream each way with valid and ready.
 * Assumes both ends share one clock; the testbench instantiates and joins it.
 */
`timescale 1ns/1ps
interface icyc_link import icyc_pkg::*;;
	logic m2s_valid;
	logic m2s_ready;
	logic [15:0] m2s_data;
	word_kind_e m2s_kind;
	logic s2m_valid;
	logic s2m_ready;
	logic [15:0] s2m_data;
	word_kind_e s2m_kind;

	modport master (output m2s_valid, m2s_data, m2s_kind, s2m_ready, input m2s_ready, s2m_valid, s2m_data, s2m_kind);
	modport drive (input m2s_valid, m2s_data, m2s_kind, s2m_ready, output m2s_ready, s2m_valid, s2m_data, s2m_kind);
endinterface : icyc_link

// File: two_entry_buffer.sv
/*
 * Small FIFO with valid and ready on both sides, used in the drive's receive path.
 * Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;

	// Handshakes and occupancy; ready is registered so the far end sees a clean level
	wire push = in_valid & ready_reg;
	wire pop = out_valid & out_ready;
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready = ready_reg;
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_ptr_reg];

	// Storage needs no reset: nothing is read before it is written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and full/empty state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_next;
			ready_reg <= count_next != (AW+1)'(DEPTH);
		end
	end
endmodule : two_entry_buffer

// File: isochronous_cycle_drive.sv
/*
 * Drive end of the isochronous cycle: decodes the master frame, runs the parameter channel,
 * captures actual values at the input instant and adopts setpoints at the output instant.
 * Assumes the master sends one global control word per cycle and one frame after it.
 */
`timescale 1ns/1ps
`include "icyc_defs.svh"
module isochronous_cycle_drive
	import icyc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	icyc_link.drive link,
	input wire logic dual_axis,
	input wire logic [15:0] act_a,
	input wire logic [15:0] stat_a,
	input wire logic [15:0] act_b,
	input wire logic [15:0] stat_b,
	input wire logic [15:0] fault_code,
	output logic [15:0] ref_a,
	output logic [15:0] ref_b,
	output logic [15:0] cmd_a,
	output logic [15:0] cmd_b,
	output logic cycle_start
);
	typedef enum {ST_RX, ST_TX} drive_state_e;

	drive_state_e state_reg;
	logic [11:0] lcnt_reg;
	logic [3:0] rx_idx_reg;
	logic [3:0] tx_idx_reg;
	logic [15:0] pid_reg [2];
	logic [15:0] resp_id_reg [2];
	logic [15:0] resp_val_reg [2];
	logic [15:0] pend_reg [2][2];
	logic [15:0] send_reg [2][2];
	logic [15:0] stage_set_reg [2];
	logic [15:0] stage_ctrl_reg [2];
	logic [1:0] stage_ok_reg;
	logic [15:0] pmem [32];
	logic s2m_valid_reg;
	logic [15:0] s2m_data_reg;
	word_kind_e s2m_kind_reg;
	logic rx_valid;
	logic [18:0] rx_word;
	logic buf_ready;

	////////////////////////////////////////////////////////////////////////
	// Receive path: the buffer absorbs words while the reply is being sent
	two_entry_buffer #(.WIDTH(19), .DEPTH(2)) rx_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(link.m2s_valid),
		.in_ready(buf_ready),
		.in_data({link.m2s_kind, link.m2s_data}),
		.out_valid(rx_valid),
		.out_ready(state_reg == ST_RX),
		.out_data(rx_word)
	);
	assign link.m2s_ready = buf_ready;

	// Word decode
	wire rx_fire = rx_valid & (state_reg == ST_RX);
	wire word_kind_e rx_kind = word_kind_e'(rx_word[18:16]);
	wire [15:0] rx_data = rx_word[15:0];
	wire [3:0] rx_slot = rx_idx_reg - 4'h1;
	wire rx_axis = rx_idx_reg >= `AXIS_B_FIRST;
	wire rx_keep = rx_fire & (rx_kind == K_PARAM | rx_kind == K_PROC) & (dual_axis | ~rx_axis); // see [R2]
	wire gc_seen = rx_fire & (rx_kind == K_GC);
	wire lcnt_wrap = lcnt_reg == `BUS_CYCLE_CLKS - 12'h1;
	wire tick = gc_seen | lcnt_wrap;
	wire param_op_e pop = param_op_e'(pid_reg[rx_axis][`POP_MSB:`POP_LSB]);
	wire [4:0] paddr = {rx_axis, pid_reg[rx_axis][`PNUM_MSB:0]};
	wire at_output = lcnt_reg == `OUTPUT_INSTANT_CLKS;

	////////////////////////////////////////////////////////////////////////
	// Local cycle clock: resynchronised by the broadcast, free-running without it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lcnt_reg <= '0;
			cycle_start <= 1'b0;
		end else begin
			lcnt_reg <= tick ? 12'h0 : lcnt_reg + 12'h1; // see [R18]
			cycle_start <= tick;
		end
	end

	// Actual values: captured at the input instant, released only at the next cycle start
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= '{default: '0};
			send_reg <= '{default: '0};
		end else begin
			if (lcnt_reg == `INPUT_INSTANT_CLKS) begin
				pend_reg <= '{'{stat_a, act_a}, '{stat_b, act_b}}; // see [R6]
			end
			if (tick) begin
				send_reg <= pend_reg; // see [R7]
			end
		end
	end

	// Parameter store; no reset, a read before any write returns unknown data
	always_ff @(posedge clk) begin
		if (rx_keep && rx_slot[1:0] == 2'h1 && pop == OP_WRITE) begin
			pmem[paddr] <= rx_data;
		end
	end

	// Frame fields: parameter channel and process value area per axis
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pid_reg <= '{default: '0};
			resp_id_reg <= '{default: '0};
			resp_val_reg <= '{default: '0};
			stage_set_reg <= '{default: '0};
			stage_ctrl_reg <= '{default: '0};
			stage_ok_reg <= '0;
			rx_idx_reg <= '0;
		end else begin
			if (rx_fire) begin
				rx_idx_reg <= (rx_kind == K_HDR) ? 4'h1 : rx_idx_reg + 4'h1; // see [R1]
			end
			if (at_output) begin
				stage_ok_reg <= '0;
			end
			if (rx_keep) begin
				case (rx_slot[1:0])
					2'h0: pid_reg[rx_axis] <= rx_data;
					2'h1: begin
						resp_id_reg[rx_axis] <= pid_reg[rx_axis] | ((pop != OP_NONE) ? 16'h2000 : 16'h0000);
						case (pop) // see [R3]
							OP_READ: resp_val_reg[rx_axis] <= pmem[paddr];
							OP_WRITE: resp_val_reg[rx_axis] <= rx_data;
							OP_FAULT: resp_val_reg[rx_axis] <= fault_code;
							default: resp_val_reg[rx_axis] <= 16'h0000;
						endcase
					end
					2'h2: begin
						if (lcnt_reg < `OUTPUT_INSTANT_CLKS) begin
							stage_ctrl_reg[rx_axis] <= rx_data; // see [R20]
						end
					end
					default: begin
						if (lcnt_reg < `OUTPUT_INSTANT_CLKS) begin
							stage_set_reg[rx_axis] <= rx_data; // see [R20]
							stage_ok_reg[rx_axis] <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// References change only at the output instant
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_a <= '0;
			ref_b <= '0;
			cmd_a <= '0;
			cmd_b <= '0;
		end else if (at_output) begin
			if (stage_ok_reg[0]) begin
				ref_a <= stage_set_reg[0]; // see [R10]
				cmd_a <= stage_ctrl_reg[0];
			end
			if (stage_ok_reg[1]) begin
				ref_b <= stage_set_reg[1]; // see [R10]
				cmd_b <= stage_ctrl_reg[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply frame word selection
	wire [3:0] tx_last = dual_axis ? `LAST_IDX_DUAL : `LAST_IDX_SINGLE;
	wire [3:0] tx_slot = tx_idx_reg - 4'h1;
	wire tx_axis = tx_idx_reg >= `AXIS_B_FIRST;
	wire can_load = ~s2m_valid_reg | link.s2m_ready;
	wire tx_first = tx_idx_reg == 4'h0;
	wire tx_end = tx_idx_reg == tx_last;
	logic [15:0] tx_data;
	word_kind_e tx_kind;
	always_comb begin
		tx_kind = tx_first ? K_HDR : (tx_end ? K_TRL : (tx_slot[1] ? K_PROC : K_PARAM));
		case (tx_slot[1:0])
			2'h0: tx_data = resp_id_reg[tx_axis];
			2'h1: tx_data = resp_val_reg[tx_axis];
			2'h2: tx_data = send_reg[tx_axis][0]; // see [R5]
			default: tx_data = send_reg[tx_axis][1];
		endcase
		if (tx_first) begin
			tx_data = {15'h0, dual_axis};
		end else if (tx_end) begin
			tx_data = {12'h0, tx_last};
		end
	end
	assign link.s2m_valid = s2m_valid_reg;
	assign link.s2m_data = s2m_data_reg;
	assign link.s2m_kind = s2m_kind_reg;

	// Reply sequencer: answers each master frame once its trailer is in
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_RX;
			tx_idx_reg <= '0;
			s2m_valid_reg <= 1'b0;
			s2m_data_reg <= '0;
			s2m_kind_reg <= K_HDR;
		end else begin
			if (link.s2m_ready) begin
				s2m_valid_reg <= 1'b0;
			end
			case (state_reg)
				ST_RX: begin
					if (rx_fire && rx_kind == K_TRL) begin
						state_reg <= ST_TX;
						tx_idx_reg <= '0;
					end
				end
				ST_TX: begin
					if (can_load) begin
						s2m_valid_reg <= 1'b1;
						s2m_data_reg <= tx_data;
						s2m_kind_reg <= tx_kind;
						tx_idx_reg <= tx_idx_reg + 4'h1;
						if (tx_end) begin
							state_reg <= ST_RX;
						end
					end
				end
				default: state_reg <= ST_RX;
			endcase
		end
	end
endmodule : isochronous_cycle_drive

// File: isochronous_cycle_master.sv
/*
 * Master end of the isochronous cycle: schedules the bus cycle, sends the global control
 * broadcast and the cyclic frame, collects the replies, then runs the acyclic, gap, token
 * and reserve phases until the cycle ends.
 * Assumes one drive slave on the link and a user that presents new setpoints before cycle end.
 */
// Functional notes
// [R1] Frame: header, per-axis parameter then process, trailer
// [R2] Second axis words only in double-axis mode
// [R3] Parameter channel reads, writes, reads faults
// [R4] Master sends control words and setpoints
// [R5] Drive answers with status words, actual values
// [R6] Drive captures actual values at input instant
// [R7] Captured values travel in the following cycle
// [R8] Computation starts strictly after exchange window
// [R9] New setpoints go out next cycle's window
// [R10] Drive adopts setpoints at output instant
// [R11] Application cycle equals bus cycle period
// [R12] Window equals sum of slave transfer times
// [R13] One global control broadcast every cycle
// [R14] Acyclic service only within token hold limit
// [R15] Gap phase admits new active stations
// [R16] Token phase passes token to self/others
// [R17] Reserve phase sends token to self
// [R18] Drive keeps cycle clock through short loss
// [R19] Broadcast first, before the exchange window
// [R20] Late setpoints ignored until next cycle
`timescale 1ns/1ps
`include "icyc_defs.svh"
module isochronous_cycle_master
	import icyc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	icyc_link.master link,
	input wire logic dual_axis,
	input wire logic [15:0] ctrl_a,
	input wire logic [15:0] set_a,
	input wire logic [15:0] ctrl_b,
	input wire logic [15:0] set_b,
	input wire logic [15:0] par_id_a,
	input wire logic [15:0] par_val_a,
	input wire logic [15:0] par_id_b,
	input wire logic [15:0] par_val_b,
	input wire logic acyc_req,
	input wire logic [15:0] acyc_word,
	input wire logic token_to_other,
	output logic [15:0] stat_a,
	output logic [15:0] act_a,
	output logic [15:0] stat_b,
	output logic [15:0] act_b,
	output logic [15:0] resp_id_a,
	output logic [15:0] resp_val_a,
	output logic [15:0] resp_id_b,
	output logic [15:0] resp_val_b,
	output logic reply_done,
	output logic compute_start,
	output logic gap_probe
);
	typedef enum {ST_GC, ST_TX, ST_WAIT, ST_ACYC, ST_GAP, ST_TOKEN, ST_RES} master_state_e;

	master_state_e state_reg;
	logic [11:0] cnt_reg;
	logic [11:0] phase_cnt_reg;
	logic [3:0] tx_idx_reg;
	logic [3:0] rx_idx_reg;
	logic dual_reg;
	logic [15:0] tx_word_reg [2][4];
	logic m2s_valid_reg;
	logic [15:0] m2s_data_reg;
	word_kind_e m2s_kind_reg;
	logic s2m_ready_reg;

	////////////////////////////////////////////////////////////////////////
	// Cycle timing derived from the one bus cycle counter
	wire cyc_last = cnt_reg == `BUS_CYCLE_CLKS - 12'h1;
	wire [11:0] win_end = dual_reg ? `WINDOW_DUAL_CLKS : `WINDOW_SINGLE_CLKS; // see [R12]
	wire [11:0] compute_at = win_end + `MASTER_OFFSET_CLKS; // see [R8]
	wire in_hold = cnt_reg < `TOKEN_HOLD_CLKS;

	// Bus cycle counter; the application cycle is this same period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			compute_start <= 1'b0;
		end else begin
			cnt_reg <= cyc_last ? 12'h0 : cnt_reg + 12'h1;
			compute_start <= cnt_reg == compute_at; // see [R11]
		end
	end

	// Setpoints and requests are frozen at cycle end, so the next window sends them whole
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_word_reg <= '{default: '0};
			dual_reg <= 1'b0;
		end else if (cyc_last) begin
			tx_word_reg <= '{'{par_id_a, par_val_a, ctrl_a, set_a}, '{par_id_b, par_val_b, ctrl_b, set_b}}; // see [R4] [R9]
			dual_reg <= dual_axis;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame word selection
	wire [3:0] tx_last = dual_reg ? `LAST_IDX_DUAL : `LAST_IDX_SINGLE; // see [R2]
	wire [3:0] tx_slot = tx_idx_reg - 4'h1;
	wire tx_axis = tx_idx_reg >= `AXIS_B_FIRST;
	wire tx_first = tx_idx_reg == 4'h0;
	wire tx_end = tx_idx_reg == tx_last;
	wire can_load = ~m2s_valid_reg | link.m2s_ready;
	wire acyc_go = (state_reg == ST_ACYC) & acyc_req & in_hold; // see [R14]
	wire res_due = (state_reg == ST_RES) & (phase_cnt_reg >= `RES_SPACING_CLKS - 12'h1);
	wire want_load = (state_reg == ST_GC) | (state_reg == ST_TX) | acyc_go | (state_reg == ST_TOKEN) | res_due;
	wire load_en = can_load & want_load;
	logic [15:0] load_data;
	word_kind_e load_kind;

	// Word to place on the link in the current state
	always_comb begin
		load_data = tx_word_reg[tx_axis][tx_slot[1:0]];
		load_kind = tx_slot[1] ? K_PROC : K_PARAM;
		case (state_reg)
			ST_GC: begin
				load_data = `GC_WORD; // see [R13]
				load_kind = K_GC;
			end
			ST_TX: begin
				if (tx_first) begin
					load_data = {15'h0, dual_reg}; // see [R1]
					load_kind = K_HDR;
				end else if (tx_end) begin
					load_data = {12'h0, tx_last};
					load_kind = K_TRL;
				end
			end
			ST_ACYC: begin
				load_data = acyc_word;
				load_kind = K_ACYC;
			end
			ST_TOKEN: begin
				load_data = token_to_other ? `TOKEN_OTHER : `TOKEN_SELF; // see [R16]
				load_kind = K_TOKEN;
			end
			ST_RES: begin
				load_data = `TOKEN_SELF; // see [R17]
				load_kind = K_TOKEN;
			end
			default: begin
				load_data = 16'h0000;
				load_kind = K_TOKEN;
			end
		endcase
	end
	assign link.m2s_valid = m2s_valid_reg;
	assign link.m2s_data = m2s_data_reg;
	assign link.m2s_kind = m2s_kind_reg;
	assign link.s2m_ready = s2m_ready_reg;

	// Output word register; a stalled word is held until the drive takes it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			m2s_valid_reg <= 1'b0;
			m2s_data_reg <= '0;
			m2s_kind_reg <= K_GC;
		end else if (load_en) begin
			m2s_valid_reg <= 1'b1;
			m2s_data_reg <= load_data;
			m2s_kind_reg <= load_kind;
		end else if (link.m2s_ready) begin
			m2s_valid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle phase sequencer; cycle end always returns to the broadcast
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_GC;
			tx_idx_reg <= '0;
			phase_cnt_reg <= '0;
			gap_probe <= 1'b0;
		end else begin
			gap_probe <= 1'b0;
			phase_cnt_reg <= phase_cnt_reg + 12'h1;
			case (state_reg)
				ST_GC: begin
					if (load_en) begin
						state_reg <= ST_TX; // see [R19]
						tx_idx_reg <= '0;
					end
				end
				ST_TX: begin
					if (load_en) begin
						tx_idx_reg <= tx_idx_reg + 4'h1;
						if (tx_end) begin
							state_reg <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (cnt_reg >= win_end) begin
						state_reg <= ST_ACYC;
					end
				end
				ST_ACYC: begin
					if (load_en || !acyc_go) begin
						state_reg <= ST_GAP;
						phase_cnt_reg <= '0;
						gap_probe <= 1'b1; // see [R15]
					end
				end
				ST_GAP: begin
					if (phase_cnt_reg >= `GAP_CLKS - 12'h1) begin
						state_reg <= ST_TOKEN;
					end
				end
				ST_TOKEN: begin
					if (load_en) begin
						state_reg <= ST_RES;
						phase_cnt_reg <= '0;
					end
				end
				ST_RES: begin
					if (load_en) begin
						phase_cnt_reg <= '0; // see [R17]
					end
				end
				default: state_reg <= ST_GC;
			endcase
			if (cyc_last) begin
				state_reg <= ST_GC; // see [R13]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply decode
	wire rx_fire = link.s2m_valid & s2m_ready_reg;
	wire [3:0] rx_slot = rx_idx_reg - 4'h1;
	wire rx_axis = rx_idx_reg >= `AXIS_B_FIRST;
	wire rx_field = rx_fire & (link.s2m_kind == K_PARAM | link.s2m_kind == K_PROC);

	// Latches status, actual values and parameter answers per axis
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s2m_ready_reg <= 1'b0;
			rx_idx_reg <= '0;
			reply_done <= 1'b0;
			{stat_a, act_a, stat_b, act_b} <= '0;
			{resp_id_a, resp_val_a, resp_id_b, resp_val_b} <= '0;
		end else begin
			s2m_ready_reg <= 1'b1;
			reply_done <= rx_fire & (link.s2m_kind == K_TRL);
			if (rx_fire) begin
				rx_idx_reg <= (link.s2m_kind == K_HDR) ? 4'h1 : rx_idx_reg + 4'h1;
			end
			if (rx_field) begin
				case ({rx_axis, rx_slot[1:0]})
					3'h0: resp_id_a <= link.s2m_data; // see [R3]
					3'h1: resp_val_a <= link.s2m_data;
					3'h2: stat_a <= link.s2m_data; // see [R5]
					3'h3: act_a <= link.s2m_data; // see [R7]
					3'h4: resp_id_b <= link.s2m_data;
					3'h5: resp_val_b <= link.s2m_data;
					3'h6: stat_b <= link.s2m_data;
					default: act_b <= link.s2m_data;
				endcase
			end
		end
	end
endmodule : isochronous_cycle_master

// File: isochronous_fieldbus_cycle_checker.sv
/* Checker on the word link between the cycle master and the drive.
   Assumes one clock, an active-low asynchronous reset, instantiated beside the link. */
`timescale 1ns/1ps
module isochronous_fieldbus_cycle_checker
	import icyc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic m2s_valid,
	input wire logic m2s_ready,
	input wire logic [15:0] m2s_data,
	input wire word_kind_e m2s_kind,
	input wire logic s2m_valid,
	input wire logic s2m_ready,
	input wire logic [15:0] s2m_data,
	input wire word_kind_e s2m_kind
);
	logic gc_take;
	logic seen_reg;
	logic [11:0] gap_reg;
	assign gc_take = m2s_valid && m2s_ready && m2s_kind == K_GC;
	// Clocks since the last broadcast; the first one after reset has no period to judge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_reg <= 12'h000;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= gc_take ? 12'h000 : gap_reg + 12'h001;
			seen_reg <= seen_reg | gc_take;
		end
	end
	////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Words stand until taken, frame markers carry their fixed contents
	m_hold_a: assert property (m2s_valid && !m2s_ready |=>
		m2s_valid && $stable(m2s_data) && $stable(m2s_kind)) else $error("master word changed early");
	s_hold_a: assert property (s2m_valid && !s2m_ready |=>
		s2m_valid && $stable(s2m_data) && $stable(s2m_kind)) else $error("drive word changed early");
	gc_word_a: assert property (m2s_valid && m2s_kind == K_GC |-> m2s_data == 16'h0001)
		else $error("bad broadcast word");
	hdr_word_a: assert property (m2s_valid && m2s_kind == K_HDR |-> m2s_data[15:1] == 15'h0000)
		else $error("bad header word");
	trl_word_a: assert property (m2s_valid && m2s_kind == K_TRL |-> m2s_data inside {16'h0005, 16'h0009})
		else $error("bad trailer word");
	token_word_a: assert property (m2s_valid && m2s_kind == K_TOKEN |-> m2s_data[15:1] == 15'h0000)
		else $error("bad token word");
	gc_first_a: assert property (gc_take |=> m2s_kind == K_HDR)
		else $error("header does not follow broadcast");
	reply_soon_a: assert property (m2s_valid && m2s_ready && m2s_kind == K_TRL |->
		##[1:12] s2m_valid && s2m_kind == K_HDR) else $error("no reply after trailer");
	cycle_len_a: assert property (gc_take && seen_reg |-> gap_reg == 12'hf9f)
		else $error("bus cycle length wrong");
endmodule : isochronous_fieldbus_cycle_checker

// File: test_isochronous_fieldbus_cycle.sv
/* Bench joining the cycle master and the drive over the word link.
   Assumes the package, link, design and checker files are compiled first. */
`timescale 1ns/1ps
`include "icyc_defs.svh"
module test_isochronous_fieldbus_cycle import icyc_pkg::*;;
	logic clk, rst_b, dual_axis, acyc_req, token_to_other, reply_done, compute_start, gap_probe, cycle_start;
	logic [15:0] ctrl_a, set_a, ctrl_b, set_b, par_id_a, par_val_a, par_id_b, par_val_b, acyc_word, fault_code;
	logic [15:0] stat_a, act_a, stat_b, act_b, resp_id_a, resp_val_a, resp_id_b, resp_val_b;
	logic [15:0] drv_act_a, drv_stat_a, drv_act_b, drv_stat_b, ref_a, ref_b, cmd_a, cmd_b, acyc_got;
	logic other_seen, gap_seen;
	int err_count, cmp_count, cyc;
	icyc_link icyc_link_inst();
	isochronous_cycle_master isochronous_cycle_master_inst (.link(icyc_link_inst.master), .*);
	isochronous_cycle_drive isochronous_cycle_drive_inst (.clk(clk), .rst_b(rst_b), .link(icyc_link_inst.drive),
		.dual_axis(dual_axis), .act_a(drv_act_a), .stat_a(drv_stat_a), .act_b(drv_act_b), .stat_b(drv_stat_b),
		.fault_code(fault_code), .ref_a(ref_a), .ref_b(ref_b), .cmd_a(cmd_a), .cmd_b(cmd_b), .cycle_start(cycle_start));
	isochronous_fieldbus_cycle_checker isochronous_fieldbus_cycle_checker_inst (.clk(clk), .rst_b(rst_b),
		.m2s_valid(icyc_link_inst.m2s_valid), .m2s_ready(icyc_link_inst.m2s_ready),
		.m2s_data(icyc_link_inst.m2s_data), .m2s_kind(icyc_link_inst.m2s_kind),
		.s2m_valid(icyc_link_inst.s2m_valid), .s2m_ready(icyc_link_inst.s2m_ready),
		.s2m_data(icyc_link_inst.s2m_data), .s2m_kind(icyc_link_inst.s2m_kind));
	////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, want);
		end
	endtask : check
	task automatic print_verdict;
		if (err_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	// Bounded wait for a pulse; a missing one shows up as stale values later
	task automatic wait_hi(ref logic sig);
		int n;
		n = 0;
		@(posedge clk);
		while (sig !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_hi
	////////////////////////////////
	// Process data both ways, then a change that must not show in the same cycle
	task automatic axis_case(input logic dual, input logic [15:0] v);
		int c0;
		dual_axis <= dual;
		set_a <= v;
		set_b <= v + 16'h1;
		ctrl_a <= v + 16'h2;
		ctrl_b <= v + 16'h3;
		drv_act_a <= v + 16'h4;
		drv_act_b <= v + 16'h5;
		drv_stat_a <= v + 16'h6;
		drv_stat_b <= v + 16'h7;
		par_id_b <= 16'hc005;
		repeat (3) wait_hi(reply_done);
		check(act_a, v + 16'h4);
		check(stat_a, v + 16'h6);
		check(cmd_a, v + 16'h2);
		check(act_b, dual ? v + 16'h5 : 16'h0);
		check(stat_b, dual ? v + 16'h7 : 16'h0);
		check(cmd_b, dual ? v + 16'h3 : 16'h0);
		check(ref_b, dual ? v + 16'h1 : 16'h0);
		check(resp_id_b, dual ? 16'he005 : 16'h0);
		check(resp_val_b, dual ? fault_code : 16'h0);
		set_a <= v + 16'h9;
		wait_hi(cycle_start);
		c0 = cyc;
		drv_act_a <= v + 16'h8;
		wait_hi(reply_done);
		check(act_a, v + 16'h4);
		check(ref_a, v);
		// Compute start lies past the window, by no more than the master offset
		wait_hi(compute_start);
		c0 = cyc - c0 - (dual ? `WINDOW_DUAL_CLKS : `WINDOW_SINGLE_CLKS);
		check(16'(c0 > 0 && c0 <= `MASTER_OFFSET_CLKS), 16'h1);
		repeat (1000) @(posedge clk);
		check(ref_a, v + 16'h9);
		wait_hi(reply_done);
		check(act_a, v + 16'h8);
	endtask : axis_case
	// Every parameter channel request, write before read on one number
	task automatic param_case;
		param_op_e ops [4];
		logic [15:0] want [4];
		logic [15:0] id;
		ops = '{OP_WRITE, OP_READ, OP_FAULT, OP_NONE};
		want = '{16'h1234, 16'h1234, 16'h0bad, 16'h0};
		for (int i = 0; i < 4; i++) begin
			id = {ops[i], 10'h000, 4'h3};
			par_id_a <= id;
			par_val_a <= want[i];
			repeat (2) wait_hi(reply_done);
			check(resp_id_a, id | (i < 3 ? 16'h2000 : 16'h0));
			check(resp_val_a, want[i]);
		end
	endtask : param_case
	// Acyclic word, gap probe and token to another master in the tail of the cycle
	task automatic phase_case;
		acyc_word <= 16'h5a5a;
		acyc_req <= 1'b1;
		token_to_other <= 1'b1;
		repeat (2) wait_hi(cycle_start);
		check(acyc_got, 16'h5a5a);
		check({14'h0, other_seen, gap_seen}, 16'h3);
	endtask : phase_case
	////////////////////////////////
	// Link watcher and hang limit, about twenty bus cycles of work
	// Flags clear at each drive cycle start, so a check sees one whole cycle
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!rst_b || cycle_start) {other_seen, gap_seen, acyc_got} <= 18'h0;
		if (icyc_link_inst.m2s_valid && icyc_link_inst.m2s_ready) begin
			if (icyc_link_inst.m2s_kind == K_ACYC) acyc_got <= icyc_link_inst.m2s_data;
			if (icyc_link_inst.m2s_kind == K_TOKEN && icyc_link_inst.m2s_data == 16'h1) other_seen <= 1'b1;
		end
		if (gap_probe) gap_seen <= 1'b1;
		if (cyc == 90000) begin
			err_count++;
			print_verdict();
		end
	end
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Reset, then the scenarios in turn
	initial begin
		rst_b = 1'b0;
		{dual_axis, acyc_req, token_to_other} = 3'h0;
		{ctrl_a, set_a, ctrl_b, set_b, par_id_a, par_val_a, par_id_b, par_val_b} = 128'h0;
		{acyc_word, drv_act_a, drv_stat_a, drv_act_b, drv_stat_b} = 80'h0;
		fault_code = 16'h0bad;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		axis_case(1'b0, 16'h1000);
		param_case();
		axis_case(1'b1, 16'h2000);
		phase_case();
		print_verdict();
	end
endmodule : test_isochronous_fieldbus_cycle
